// file: verilog/abic_cfg.svh
// Timing and layout constants for the converter bus interface
`ifndef ABIC_CFG_SVH
`define ABIC_CFG_SVH
`define ABIC_CONV_CYCLES 20
`define ABIC_ZERO_CYCLES 3
`define ABIC_RESULT_BITS 12
`define ABIC_LOW_BYTE_MSB 7
`define ABIC_HIGH_BYTE_LSB 8
`define ABIC_EOC_RESET 1'b1
`endif

// file: verilog/abic_pkg.sv
// Types for the converter bus interface
package abic_pkg;
    typedef enum logic [1:0] {
        ABIC_IDLE = 2'b00,
        ABIC_CONV = 2'b01,
        ABIC_ZERO = 2'b11
    } abic_state_t;
endpackage : abic_pkg

// file: verilog/abic_sync.sv
// Two-flop synchroniser for one pin
`timescale 1ns/100ps
module abic_sync #(
    parameter logic RESET_VALUE = 1'b1
) (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic pin_in,
    output logic level_out
);
    logic stage1;

    always_ff @(posedge clock_in)
    begin
        if (!rst_b_in)
        begin
            stage1 <= RESET_VALUE;
            level_out <= RESET_VALUE;
        end
        else
        begin
            stage1 <= pin_in;
            level_out <= stage1;
        end
    end
endmodule : abic_sync

// file: verilog/abic_top.sv
// Bus interface and sequencer of the 12-bit converter
`timescale 1ns/100ps
`include "abic_cfg.svh"
module abic_top #(
    parameter int CONV_CYCLES = `ABIC_CONV_CYCLES,
    parameter int ZERO_CYCLES = `ABIC_ZERO_CYCLES
) (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic chip_select_b_in,
    input wire logic write_b_in,
    input wire logic read_b_in,
    input wire logic byte_address_in,
    input wire logic wide_bus_in,
    input wire logic [12:0] sample_in,
    output logic [7:0] data_low_out,
    output logic [7:0] data_high_out,
    output logic data_low_oe_out,
    output logic data_high_oe_out,
    output logic end_of_conversion_out,
    output logic overrange_flag_out,
    output logic zeroing_out
);
    logic cs_b;
    logic wr_b;
    logic rd_b;
    logic addr;
    logic wide;
    logic wr_b_prev;
    logic start;
    logic [4:0] cycle;
    logic [12:0] result;
    abic_pkg::abic_state_t state;

    abic_sync #(.RESET_VALUE(1'b1)) u_cs (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .pin_in(chip_select_b_in), .level_out(cs_b));
    abic_sync #(.RESET_VALUE(1'b1)) u_wr (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .pin_in(write_b_in), .level_out(wr_b));
    abic_sync #(.RESET_VALUE(1'b1)) u_rd (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .pin_in(read_b_in), .level_out(rd_b));
    abic_sync #(.RESET_VALUE(1'b0)) u_a0 (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .pin_in(byte_address_in), .level_out(addr));
    abic_sync #(.RESET_VALUE(1'b0)) u_bus (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .pin_in(wide_bus_in), .level_out(wide));

    // Falling write edge while selected
    always_ff @(posedge clock_in)
    begin
        if (!rst_b_in)
            wr_b_prev <= 1'b1;
        else
            wr_b_prev <= wr_b;
    end

    assign start = wr_b_prev && !wr_b && !cs_b;

    // Sequencer
    always_ff @(posedge clock_in)
    begin
        if (!rst_b_in)
        begin
            state <= abic_pkg::ABIC_IDLE;
            cycle <= 5'h00;
        end
        else if (start)
        begin
            state <= abic_pkg::ABIC_CONV;
            cycle <= 5'h00;
        end
        else
        begin
            unique case (state)
                abic_pkg::ABIC_IDLE:
                    cycle <= 5'h00;
                abic_pkg::ABIC_CONV:
                begin
                    cycle <= cycle + 5'h01;
                    if (cycle == 5'(CONV_CYCLES - ZERO_CYCLES - 1))
                        state <= abic_pkg::ABIC_ZERO;
                end
                abic_pkg::ABIC_ZERO:
                begin
                    cycle <= cycle + 5'h01;
                    if (cycle == 5'(CONV_CYCLES - 1))
                        state <= abic_pkg::ABIC_IDLE;
                end
                default:
                    state <= abic_pkg::ABIC_IDLE;
            endcase
        end
    end

    // Result latch after the last cycle
    always_ff @(posedge clock_in)
    begin
        if (!rst_b_in)
            result <= 13'h0000;
        else if (state == abic_pkg::ABIC_ZERO && cycle == 5'(CONV_CYCLES - 1) && !start)
            result <= sample_in;
    end

    // End flag and zeroing indicator
    always_ff @(posedge clock_in)
    begin
        if (!rst_b_in)
        begin
            end_of_conversion_out <= `ABIC_EOC_RESET;
            zeroing_out <= 1'b0;
        end
        else
        begin
            if (start)
                end_of_conversion_out <= 1'b0;
            else if (state == abic_pkg::ABIC_ZERO && cycle == 5'(CONV_CYCLES - 1))
                end_of_conversion_out <= 1'b1;
            zeroing_out <= (state == abic_pkg::ABIC_CONV
                && cycle == 5'(CONV_CYCLES - ZERO_CYCLES - 1) && !start)
                || (state == abic_pkg::ABIC_ZERO && cycle != 5'(CONV_CYCLES - 1)
                && !start);
        end
    end

    // Output steering
    always_ff @(posedge clock_in)
    begin
        if (!rst_b_in)
        begin
            data_low_out <= 8'h00;
            data_high_out <= 8'h00;
            data_low_oe_out <= 1'b0;
            data_high_oe_out <= 1'b0;
            overrange_flag_out <= 1'b0;
        end
        else
        begin
            data_low_out <= result[`ABIC_LOW_BYTE_MSB:0];
            if (wide)
                data_high_out <= {4'h0, result[11:`ABIC_HIGH_BYTE_LSB]};
            else if (addr)
                data_high_out <= {4'h0, result[11:`ABIC_HIGH_BYTE_LSB]};
            else
                data_high_out <= 8'h00;
            overrange_flag_out <= result[12];
            if (rd_b || cs_b)
            begin
                data_low_oe_out <= 1'b0;
                data_high_oe_out <= 1'b0;
            end
            else if (wide)
            begin
                data_low_oe_out <= 1'b1;
                data_high_oe_out <= 1'b1;
            end
            else
            begin
                data_low_oe_out <= !addr;
                data_high_oe_out <= addr;
            end
        end
    end

    // Latched byte must match address
    low_byte_sel_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (data_low_oe_out && !data_high_oe_out) |-> !$past(addr) && !$past(rd_b)
        && !$past(cs_b)) else $error("low byte enabled wrongly");

    start_clears_eoc_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        start |=> !end_of_conversion_out) else $error("eoc not cleared on start");
    eoc_after_twenty_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        start ##1 (!start)[*8] ##1 (!start)[*8] ##1 (!start)[*4]
        |=> end_of_conversion_out) else $error("eoc late");
    eoc_low_busy_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        state != abic_pkg::ABIC_IDLE |-> !end_of_conversion_out) else
        $error("eoc high while busy");
    eoc_rise_valid_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        $rose(end_of_conversion_out) |-> result == $past(sample_in)) else
        $error("eoc rose without result");
    read_high_off_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        $past(rd_b) |-> !data_low_oe_out && !data_high_oe_out) else
        $error("drive while read high");
    deselect_idle_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (cs_b && state == abic_pkg::ABIC_IDLE) |=> state == abic_pkg::ABIC_IDLE) else
        $error("start while deselected");
    wide_both_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (wide && !rd_b && !cs_b) |=> data_low_oe_out && data_high_oe_out) else
        $error("wide read not both");
    byte_high_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (!wide && addr && !rd_b && !cs_b) |=> data_high_oe_out && !data_low_oe_out) else
        $error("high byte not chosen");
    zero_three_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        $rose(zeroing_out) |-> zeroing_out[*3]) else $error("zeroing not three");
    start_conv_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        start |=> state == abic_pkg::ABIC_CONV && cycle == 5'h00) else
        $error("start not taken");
    select_read_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (data_low_oe_out || data_high_oe_out) |-> !$past(cs_b) && !$past(rd_b)) else
        $error("drive without select and read");
    byte_low_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (!wide && !addr && !rd_b && !cs_b) |=> data_low_oe_out && !data_high_oe_out) else
        $error("low byte not chosen");
    eoc_stays_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (end_of_conversion_out && !start) |=> end_of_conversion_out) else
        $error("eoc dropped without start");
endmodule : abic_top

// file: bench/abic_host.sv
// Host model driving the converter bus pins
`timescale 1ns/100ps
module abic_host (
    input wire logic clock_in,
    output logic chip_select_b_out,
    output logic write_b_out,
    output logic read_b_out,
    output logic byte_address_out,
    output logic wide_bus_out,
    output logic [12:0] sample_out
);
    initial
    begin
        {chip_select_b_out, write_b_out, read_b_out} = 3'h7;
        {byte_address_out, wide_bus_out, sample_out} = 15'h0000;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask : cyc
    task automatic start(input logic sel_b, input logic [12:0] s);
        cyc(1);
        sample_out = s;
        chip_select_b_out = sel_b;
        write_b_out = 1'b0;
        cyc(3);
        write_b_out = 1'b1;
        chip_select_b_out = 1'b1;
    endtask : start
    task automatic read(input logic w, input logic a);
        cyc(1);
        wide_bus_out = w;
        byte_address_out = a;
        chip_select_b_out = 1'b0;
        read_b_out = 1'b0;
        cyc(6);
        read_b_out = 1'b1;
        chip_select_b_out = 1'b1;
        cyc(4);
    endtask : read
endmodule : abic_host

// file: bench/abic_top_tb_top.sv
// Self-checking bench of the converter bus interface
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module abic_top_tb_top;
    logic clock_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic cs_b, wr_b, rd_b, a0, wide, oel, oeh, eoc, overrange_flag, zer;
    logic oe_d = 1'b0;
    logic [12:0] smp, s;
    logic [7:0] lo, hi;
    logic [18:0] exp_q[$];
    int errors = 0;
    int checks_done = 0;
    int n, zc;
    abic_host host (.clock_in(clock_in), .chip_select_b_out(cs_b), .write_b_out(wr_b),
        .read_b_out(rd_b), .byte_address_out(a0), .wide_bus_out(wide), .sample_out(smp));
    abic_top dut (.clock_in(clock_in), .rst_b_in(rst_b_in), .chip_select_b_in(cs_b),
        .write_b_in(wr_b), .read_b_in(rd_b), .byte_address_in(a0), .wide_bus_in(wide),
        .sample_in(smp), .data_low_out(lo), .data_high_out(hi), .data_low_oe_out(oel),
        .data_high_oe_out(oeh), .end_of_conversion_out(eoc), .overrange_flag_out(overrange_flag),
        .zeroing_out(zer));
    initial
    begin
        forever #2.5 clock_in = ~clock_in;
    end
    task automatic stop_test();
        if (errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test
    always @(posedge clock_in)
    begin
        if ((oel | oeh) === 1'b1 && oe_d === 1'b0)
            `CHK({overrange_flag, oeh, oel, hi, lo}, exp_q.pop_front())
        oe_d <= oel | oeh;
    end
    initial
    begin
        n = $urandom(89);
        repeat (16) @(posedge clock_in);
        #1 rst_b_in = 1'b1;
        host.cyc(4);
        host.start(1'b1, 13'h1fff);
        host.cyc(5);
        `CHK(eoc, 1'b1)
        host.cyc(25);
        for (int i = 0; i < 4; i++)
        begin
            s = (i == 0) ? 13'h0fff : (i == 1) ? 13'h107a : 13'($urandom());
            if (s[12])
                s[11:0] = 12'(s[11:0] % 12'h07b);
            host.start(1'b0, s);
            if (i == 3)
                host.cyc(25);
            n = 0;
            zc = 0;
            while (eoc !== 1'b1 && n < 100)
            begin
                n++;
                zc += int'(zer === 1'b1);
                host.cyc(1);
            end
            `CHK(n, (i == 3) ? 0 : 20)
            `CHK(zc, (i == 3) ? 0 : 3)
            if (n >= 100)
                stop_test();
            for (int j = 0; j < 3; j++)
            begin
                exp_q.push_back({s[12], j != 0, j != 1,
                    (j != 0) ? {4'h0, s[11:8]} : 8'h00, s[7:0]});
                host.read(j == 2, j == 1);
                `CHK({oeh, oel}, 2'b00)
            end
        end
        `CHK(exp_q.size(), 0)
        stop_test();
    end
endmodule : abic_top_tb_top
